// ---- hdl/swc_defines.vh ----
// Shared constants for the write-through cache pair
`ifndef SWC_DEFINES_VH
`define SWC_DEFINES_VH
`define SWC_BYTES_PER_LINE 16
`define SWC_LINES_PER_WAY 128
`define SWC_WAYS 2
`define SWC_CACHE_BASE 32'h00000000
`define SWC_CACHE_LIMIT 32'h0fffffff
`define SWC_INLINE_BASE 32'h10000000
`define SWC_INLINE_LIMIT 32'h1000ffff
`define SWC_SEL_ALL 4'hf
`endif

// ---- hdl/swc_cache.v ----
// One write-through cache: tags, data, refill, bypass and invalidate
`timescale 1ns/100ps
`default_nettype none
`include "swc_defines.vh"
module swc_cache #(
  parameter BYTES_PER_LINE = `SWC_BYTES_PER_LINE,
  parameter LINES_PER_WAY = `SWC_LINES_PER_WAY,
  parameter WAYS = `SWC_WAYS,
  parameter [31:0] CACHE_BASE = `SWC_CACHE_BASE,
  parameter [31:0] CACHE_LIMIT = `SWC_CACHE_LIMIT,
  parameter [31:0] INLINE_BASE = `SWC_INLINE_BASE,
  parameter [31:0] INLINE_LIMIT = `SWC_INLINE_LIMIT
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_resetn,
  // Requester side
  input wire i_req,
  input wire i_we,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire [3:0] i_sel,
  input wire i_inval,
  output reg o_ack,
  output reg [31:0] o_rdata,
  output reg o_busy,
  // Wishbone master
  output reg o_wb_cyc,
  output reg o_wb_stb,
  output reg o_wb_we,
  output reg [31:0] o_wb_adr,
  output reg [31:0] o_wb_dat,
  output reg [3:0] o_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire i_wb_ack
);
  localparam WPL = BYTES_PER_LINE / 4;
  localparam OFFB = (WPL == 4) ? 2 : (WPL == 2) ? 1 : 0;
  localparam IDXB = $clog2(LINES_PER_WAY);
  localparam TAGB = 32 - 2 - OFFB - IDXB;
  localparam WB = (OFFB == 0) ? 1 : OFFB;
  localparam DEPTH = LINES_PER_WAY * WPL;
  localparam ST_INIT = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_FILL = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_BYP = 3'h4;
  localparam ST_DONE = 3'h5;

  reg [2:0] state_q;
  reg [IDXB-1:0] clr_q;
  reg way_ptr_q;
  reg fill_way_q;
  reg [WB-1:0] fill_cnt_q;
  reg [31:0] addr_q;
  reg inval_pend_q;
  reg [TAGB-1:0] tag_mem [0:WAYS*LINES_PER_WAY-1];
  reg [31:0] data_mem [0:WAYS*DEPTH-1];
  reg [WAYS*LINES_PER_WAY-1:0] valid_q;

  wire [IDXB-1:0] idx = i_addr[2+OFFB+IDXB-1:2+OFFB];
  wire [TAGB-1:0] tag = i_addr[31:32-TAGB];
  wire [WB-1:0] woff;
  wire cacheable;
  wire [WAYS-1:0] hit_w;
  wire hit;
  wire hit_way;
  wire [IDXB-1:0] fidx = addr_q[2+OFFB+IDXB-1:2+OFFB];
  generate
    if (OFFB == 0) begin : g_off0
      assign woff = 1'b0;
    end else begin : g_off
      assign woff = i_addr[2+OFFB-1:2];
    end
  endgenerate
  // Inline-memory addresses and out-of-range addresses bypass the cache
  assign cacheable = (i_addr >= CACHE_BASE) &&
    (i_addr <= CACHE_LIMIT) &&
    !((i_addr >= INLINE_BASE) && (i_addr <= INLINE_LIMIT));
  genvar w;
  generate
    for (w = 0; w < WAYS; w = w + 1) begin : g_hit
      // Each way offers one candidate line per set
      assign hit_w[w] = valid_q[w*LINES_PER_WAY+idx] &&
        (tag_mem[w*LINES_PER_WAY+idx] == tag);
    end
  endgenerate
  assign hit = |hit_w;
  assign hit_way = (WAYS == 2) ? hit_w[WAYS-1] : 1'b0;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  always @(posedge i_sys_clk) begin
    // Refill word and write hit update
    if (state_q == ST_FILL && i_wb_ack) begin
      data_mem[{fill_way_q, fidx, fill_cnt_q}] <= i_wb_dat;
    end else if (state_q == ST_IDLE && i_req && i_we && cacheable && hit &&
                 !i_inval) begin
      data_mem[{hit_way, idx, woff}] <=
        merge(data_mem[{hit_way, idx, woff}], i_wdata, i_sel);
    end
    if (state_q == ST_IDLE && i_req && !i_we && cacheable && !hit &&
        !i_inval) begin
      tag_mem[{way_ptr_q, idx}] <= tag;
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_INIT;
      clr_q <= {IDXB{1'b0}};
      way_ptr_q <= 1'b0;
      fill_way_q <= 1'b0;
      fill_cnt_q <= {WB{1'b0}};
      addr_q <= 32'h00000000;
      inval_pend_q <= 1'b0;
      valid_q <= {WAYS*LINES_PER_WAY{1'b0}};
      o_ack <= 1'b0;
      o_rdata <= 32'h00000000;
      o_busy <= 1'b1;
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      o_wb_we <= 1'b0;
      o_wb_adr <= 32'h00000000;
      o_wb_dat <= 32'h00000000;
      o_wb_sel <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      if (i_inval) begin
        inval_pend_q <= 1'b1;
      end
      case (state_q)
        ST_INIT: begin
          // Clear one set per cycle; lookups wait meanwhile
          valid_q[clr_q] <= 1'b0;
          if (WAYS == 2) begin
            valid_q[LINES_PER_WAY+clr_q] <= 1'b0;
          end
          // Running sweep already covers a new invalidate
          inval_pend_q <= 1'b0;
          clr_q <= clr_q + 1'b1;
          if (clr_q == LINES_PER_WAY - 1) begin
            state_q <= ST_IDLE;
            o_busy <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (i_inval || inval_pend_q) begin
            state_q <= ST_INIT;
            inval_pend_q <= 1'b0;
            clr_q <= {IDXB{1'b0}};
            o_busy <= 1'b1;
          end else if (i_req) begin
            addr_q <= i_addr;
            o_busy <= 1'b1;
            o_wb_adr <= {i_addr[31:2], 2'b00};
            o_wb_dat <= i_wdata;
            o_wb_sel <= i_sel;
            if (i_we) begin
              // Every store goes to memory, hit or miss
              state_q <= ST_WRITE;
              o_wb_cyc <= 1'b1;
              o_wb_stb <= 1'b1;
              o_wb_we <= 1'b1;
            end else if (cacheable && hit) begin
              o_rdata <= data_mem[{hit_way, idx, woff}];
              o_ack <= 1'b1;
              state_q <= ST_DONE;
            end else if (cacheable) begin
              // Load miss allocates into the round-robin way
              state_q <= ST_FILL;
              fill_way_q <= way_ptr_q;
              if (WAYS == 2) begin
                way_ptr_q <= ~way_ptr_q;
              end
              fill_cnt_q <= {WB{1'b0}};
              valid_q[{way_ptr_q, idx}] <= 1'b0;
              o_wb_adr <= {i_addr[31:2+OFFB], {OFFB{1'b0}}, 2'b00};
              o_wb_sel <= `SWC_SEL_ALL;
              o_wb_cyc <= 1'b1;
              o_wb_stb <= 1'b1;
              o_wb_we <= 1'b0;
            end else begin
              state_q <= ST_BYP;
              o_wb_cyc <= 1'b1;
              o_wb_stb <= 1'b1;
              o_wb_we <= 1'b0;
            end
          end
        end
        ST_FILL: begin
          if (i_wb_ack) begin
            if (fill_cnt_q == addr_q[2+WB-1:2] || OFFB == 0) begin
              o_rdata <= i_wb_dat;
            end
            fill_cnt_q <= fill_cnt_q + 1'b1;
            o_wb_adr <= o_wb_adr + 32'h00000004;
            if (fill_cnt_q == WPL - 1 || OFFB == 0) begin
              o_wb_cyc <= 1'b0;
              o_wb_stb <= 1'b0;
              valid_q[{fill_way_q, fidx}] <= !(i_inval || inval_pend_q);
              o_ack <= 1'b1;
              state_q <= ST_DONE;
            end
          end
        end
        ST_WRITE, ST_BYP: begin
          if (i_wb_ack) begin
            o_wb_cyc <= 1'b0;
            o_wb_stb <= 1'b0;
            o_wb_we <= 1'b0;
            o_rdata <= i_wb_dat;
            o_ack <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        default: begin
          // Stay busy if an invalidate arrived during the request
          if (i_inval || inval_pend_q) begin
            state_q <= ST_INIT;
            inval_pend_q <= 1'b0;
            clr_q <= {IDXB{1'b0}};
          end else begin
            o_busy <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hdl/swc_top.v ----
// Instruction and data write-through caches for the soft processor
// How it works
// - Lines hold 8 or 16 bytes by build option; with 4-byte lines the data index runs past the end of the data array.
// - Direct-mapped build maps each address to one line.
// - Two-way build lets an address sit in either way of its set.
// - Lines per way set separately per cache, 128 to 1024.
// - Refill way pointer toggles on every cacheable load miss in the two-way build; direct-mapped keeps it at 0.
// - Store hit updates cache and also writes memory.
// - Only load misses fetch and allocate a line.
// - Store miss goes to memory without touching the cache.
// - Hardware clears all lines after reset, no software needed.
// - Any instruction-invalidate write clears the instruction cache.
// - Any data-invalidate write clears the whole data cache.
// - Data stores never change instruction cache contents.
// - No snooping; other masters' writes leave lines alone.
// - Inline-memory addresses are never looked up or allocated.
// - A miss starts a bus transaction and stalls the requester.
// - Every data write makes a bus access.
// - A hit returns data in a single cycle.
// - Cacheable range is a build setting per cache.
// - Fetches outside the cacheable range bypass the cache as single bus reads.
`timescale 1ns/100ps
`default_nettype none
`include "swc_defines.vh"
module swc_top #(
  parameter BYTES_PER_LINE = `SWC_BYTES_PER_LINE,
  parameter INSTR_LINES_PER_WAY = `SWC_LINES_PER_WAY,
  parameter DATA_LINES_PER_WAY = `SWC_LINES_PER_WAY,
  parameter WAYS = `SWC_WAYS,
  parameter [31:0] I_CACHE_BASE = `SWC_CACHE_BASE,
  parameter [31:0] I_CACHE_LIMIT = `SWC_CACHE_LIMIT,
  parameter [31:0] D_CACHE_BASE = `SWC_CACHE_BASE,
  parameter [31:0] D_CACHE_LIMIT = `SWC_CACHE_LIMIT
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_resetn,
  // Fetch port
  input wire i_if_req,
  input wire [31:0] i_if_addr,
  output wire o_if_ack,
  output wire [31:0] o_if_data,
  output wire o_if_busy,
  // Load/store port
  input wire i_ls_req,
  input wire i_ls_we,
  input wire [31:0] i_ls_addr,
  input wire [31:0] i_ls_wdata,
  input wire [3:0] i_ls_sel,
  output wire o_ls_ack,
  output wire [31:0] o_ls_rdata,
  output wire o_ls_busy,
  // Invalidate control writes
  input wire i_instr_cache_invalidate_reg_wr,
  input wire i_data_cache_invalidate_reg_wr,
  // Instruction Wishbone
  output wire o_iwb_cyc,
  output wire o_iwb_stb,
  output wire [31:0] o_iwb_adr,
  input wire [31:0] i_iwb_dat,
  input wire i_iwb_ack,
  // Data Wishbone
  output wire o_dwb_cyc,
  output wire o_dwb_stb,
  output wire o_dwb_we,
  output wire [31:0] o_dwb_adr,
  output wire [31:0] o_dwb_dat,
  output wire [3:0] o_dwb_sel,
  input wire [31:0] i_dwb_dat,
  input wire i_dwb_ack
);
  // Fetch side never writes, so stores cannot reach it
  // Separate line counts per cache
  swc_cache #(
    .BYTES_PER_LINE(BYTES_PER_LINE),
    .LINES_PER_WAY(INSTR_LINES_PER_WAY),
    .WAYS(WAYS),
    .CACHE_BASE(I_CACHE_BASE),
    .CACHE_LIMIT(I_CACHE_LIMIT)
  ) u_icache (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_req(i_if_req),
    .i_we(1'b0),
    .i_addr(i_if_addr),
    .i_wdata(32'h00000000),
    .i_sel(`SWC_SEL_ALL),
    .i_inval(i_instr_cache_invalidate_reg_wr),
    .o_ack(o_if_ack),
    .o_rdata(o_if_data),
    .o_busy(o_if_busy),
    .o_wb_cyc(o_iwb_cyc),
    .o_wb_stb(o_iwb_stb),
    .o_wb_we(),
    .o_wb_adr(o_iwb_adr),
    .o_wb_dat(),
    .o_wb_sel(),
    .i_wb_dat(i_iwb_dat),
    .i_wb_ack(i_iwb_ack)
  );
  swc_cache #(
    .BYTES_PER_LINE(BYTES_PER_LINE),
    .LINES_PER_WAY(DATA_LINES_PER_WAY),
    .WAYS(WAYS),
    .CACHE_BASE(D_CACHE_BASE),
    .CACHE_LIMIT(D_CACHE_LIMIT)
  ) u_dcache (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_req(i_ls_req),
    .i_we(i_ls_we),
    .i_addr(i_ls_addr),
    .i_wdata(i_ls_wdata),
    .i_sel(i_ls_sel),
    .i_inval(i_data_cache_invalidate_reg_wr),
    .o_ack(o_ls_ack),
    .o_rdata(o_ls_rdata),
    .o_busy(o_ls_busy),
    .o_wb_cyc(o_dwb_cyc),
    .o_wb_stb(o_dwb_stb),
    .o_wb_we(o_dwb_we),
    .o_wb_adr(o_dwb_adr),
    .o_wb_dat(o_dwb_dat),
    .o_wb_sel(o_dwb_sel),
    .i_wb_dat(i_dwb_dat),
    .i_wb_ack(i_dwb_ack)
  );
endmodule
`default_nettype wire

// ---- test/swc_wb_mem.sv ----
// Behavioural Wishbone memory for one cache bus
`timescale 1ns/100ps
`default_nettype none
module swc_wb_mem (
  // Clock, reset and pacing
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_slow,
  // Wishbone slave
  input wire logic i_cyc,
  input wire logic i_stb,
  input wire logic i_we,
  input wire logic [31:0] i_adr,
  input wire logic [31:0] i_dat,
  input wire logic [3:0] i_sel,
  output logic [31:0] o_dat,
  output logic o_ack
);
  logic [31:0] mem [0:4095];
  logic [1:0] wait_q;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 32'h5a000000 | i;
    end
  end
  // Data line toggles whenever no answer is on it
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack <= 1'b0;
      wait_q <= 2'h0;
      o_dat <= 32'h0;
    end else begin
      o_ack <= 1'b0;
      o_dat <= ~o_dat;
      if (i_cyc && i_stb && !o_ack) begin
        if (!i_slow || wait_q == 2'h2) begin
          o_ack <= 1'b1;
          wait_q <= 2'h0;
          o_dat <= mem[i_adr[13:2]];
          for (int b = 0; b < 4; b++) begin
            if (i_we && i_sel[b]) begin
              mem[i_adr[13:2]][8*b +: 8] <= i_dat[8*b +: 8];
            end
          end
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/swc_checker_asserts.sv ----
// Port assertions for the cache pair
`timescale 1ns/100ps
`default_nettype none
module swc_checker (
  // Clock, reset, load/store port, fetch busy and data invalidate
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ls_req,
  input wire logic i_ls_we,
  input wire logic [31:0] i_ls_addr,
  input wire logic [31:0] i_ls_wdata,
  input wire logic o_ls_ack,
  input wire logic o_ls_busy,
  input wire logic o_if_busy,
  input wire logic i_data_cache_invalidate_reg_wr,
  // Data bus
  input wire logic o_dwb_cyc,
  input wire logic o_dwb_stb,
  input wire logic o_dwb_we,
  input wire logic [31:0] o_dwb_adr,
  input wire logic [31:0] o_dwb_dat,
  input wire logic [3:0] o_dwb_sel,
  input wire logic i_dwb_ack
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  wire st_take = i_ls_req && i_ls_we && !o_ls_busy &&
    !i_data_cache_invalidate_reg_wr;
  AST_INIT: assert property ($rose(i_resetn) |->
    (o_ls_busy && o_if_busy) [*8]) else $error("busy low after reset");
  AST_STORE_BUS: assert property (st_take |=>
    o_dwb_cyc && o_dwb_stb && o_dwb_we) else $error("store not on bus");
  AST_STORE_DATA: assert property (st_take |=>
    o_dwb_adr == $past(i_ls_addr) && o_dwb_dat == $past(i_ls_wdata))
    else $error("store bus value wrong");
  AST_HOLD: assert property (o_dwb_stb && !i_dwb_ack |=>
    o_dwb_stb && $stable(o_dwb_adr)) else $error("bus request dropped");
  AST_BURST: assert property (o_dwb_stb && i_dwb_ack && !o_dwb_we
    ##1 o_dwb_stb |-> o_dwb_adr == $past(o_dwb_adr) + 32'h4)
    else $error("refill address step wrong");
  AST_ALIGN: assert property ($rose(o_dwb_cyc) && !o_dwb_we &&
    o_dwb_adr < 32'h10000000 |-> o_dwb_adr[3:0] == 4'h0 &&
    o_dwb_sel == 4'hf) else $error("refill start wrong");
  AST_ACK_END: assert property ($fell(o_dwb_cyc) |-> o_ls_ack)
    else $error("no answer after bus cycle");
  AST_INVAL: assert property (i_data_cache_invalidate_reg_wr &&
    !o_ls_busy |=> o_ls_busy [*8]) else $error("not busy on invalidate");
  cover property (st_take);
  cover property ($fell(o_dwb_cyc) && !$past(o_dwb_we));
  cover property (i_data_cache_invalidate_reg_wr);
  cover property (i_data_cache_invalidate_reg_wr && o_dwb_cyc);
endmodule
bind swc_top swc_checker u_chk (.*);
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the cache pair
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic ifq = 1'b0, lsq = 1'b0, lwe = 1'b0, iinv = 1'b0, dinv = 1'b0;
  logic [31:0] ifa = 32'h0, lsa = 32'h0, lwd = 32'h0;
  logic [3:0] lsl = 4'hf, bsel = 4'hf;
  logic [31:0] rd, lat, bt;
  wire ifk, ifb, lsk, lsb, icyc, istb, iack, dcyc, dstb, dwe, dack;
  wire [31:0] ifd, lsd, iadr, idat, dadr, ddat, drd;
  wire [3:0] dsel;
  int n_mismatch = 0, checks = 0, ib = 0, db = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (iack) ib <= ib + 1;
    if (dack) db <= db + 1;
  end
  swc_top u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_if_req(ifq),
    .i_if_addr(ifa), .o_if_ack(ifk), .o_if_data(ifd), .o_if_busy(ifb),
    .i_ls_req(lsq), .i_ls_we(lwe), .i_ls_addr(lsa), .i_ls_wdata(lwd),
    .i_ls_sel(lsl), .o_ls_ack(lsk), .o_ls_rdata(lsd), .o_ls_busy(lsb),
    .i_instr_cache_invalidate_reg_wr(iinv),
    .i_data_cache_invalidate_reg_wr(dinv), .o_iwb_cyc(icyc),
    .o_iwb_stb(istb), .o_iwb_adr(iadr), .i_iwb_dat(idat), .i_iwb_ack(iack),
    .o_dwb_cyc(dcyc), .o_dwb_stb(dstb), .o_dwb_we(dwe), .o_dwb_adr(dadr),
    .o_dwb_dat(ddat), .o_dwb_sel(dsel), .i_dwb_dat(drd), .i_dwb_ack(dack));
  swc_wb_mem u_imem (.i_sys_clk(clk), .i_resetn(rstn), .i_slow(slow),
    .i_cyc(icyc), .i_stb(istb), .i_we(1'b0), .i_adr(iadr), .i_dat(32'h0),
    .i_sel(4'h0), .o_dat(idat), .o_ack(iack));
  swc_wb_mem u_dmem (.i_sys_clk(clk), .i_resetn(rstn), .i_slow(slow),
    .i_cyc(dcyc), .i_stb(dstb), .i_we(dwe), .i_adr(dadr), .i_dat(ddat),
    .i_sel(dsel), .o_dat(drd), .o_ack(dack));
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One fetch (f=1) or load/store; keeps answer, latency, bus beats
  task automatic acc(input bit f, input bit we, input logic [31:0] a, w);
    int b0, n;
    do @(negedge clk); while ((f ? ifb : lsb) !== 1'b0);
    b0 = f ? ib : db;
    @(posedge clk);
    ifq <= f;
    lsq <= !f;
    lwe <= we;
    ifa <= a;
    lsa <= a;
    lwd <= w;
    lsl <= bsel;
    @(posedge clk);
    ifq <= 1'b0;
    lsq <= 1'b0;
    n = 0;
    do begin
      n++;
      @(negedge clk);
    end while ((f ? ifk : lsk) !== 1'b1 && n < 80);
    chk({31'h0, (f ? ifk : lsk)}, 32'h1);
    rd = f ? ifd : lsd;
    lat = n;
    bt = (f ? ib : db) - b0;
  endtask
  task automatic inval(input bit f);
    do @(negedge clk); while (lsb !== 1'b0 || ifb !== 1'b0);
    @(posedge clk);
    iinv <= f;
    dinv <= !f;
    @(posedge clk);
    iinv <= 1'b0;
    dinv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_init;
    int n;
    n = 0;
    do begin
      n++;
      @(negedge clk);
    end while ((lsb !== 1'b0 || ifb !== 1'b0) && n < 300);
    chk({31'h0, n >= 128 && n <= 136}, 32'h1);
  endtask
  task automatic t_miss_hit;
    acc(0, 0, 32'h100, 0);
    chk(rd, 32'h5a000040);
    chk(bt, 32'h4);
    acc(0, 0, 32'h10c, 0);
    chk(rd, 32'h5a000043);
    chk(lat, 32'h1);
    chk(bt, 32'h0);
  endtask
  task automatic t_store;
    slow = 1'b1;
    acc(0, 1, 32'h104, 32'hcafe0001);
    chk(bt, 32'h1);
    acc(0, 0, 32'h104, 0);
    chk(rd, 32'hcafe0001);
    chk(bt, 32'h0);
    bsel = 4'h1;
    acc(0, 1, 32'h104, 32'h000000ee);
    bsel = 4'hf;
    chk(u_dmem.mem[65], 32'hcafe00ee);
    acc(0, 0, 32'h104, 0);
    chk(rd, 32'hcafe00ee);
    acc(0, 1, 32'h200, 32'hcafe0002);
    acc(0, 0, 32'h200, 0);
    chk(bt, 32'h4);
    chk(rd, 32'hcafe0002);
    slow = 1'b0;
  endtask
  task automatic t_rr;
    acc(0, 0, 32'h300, 0);
    acc(0, 0, 32'hb00, 0);
    acc(0, 0, 32'h300, 0);
    chk(bt, 32'h0);
    acc(0, 0, 32'h1300, 0);
    chk(rd, 32'h5a0004c0);
    acc(0, 0, 32'hb00, 0);
    chk(bt, 32'h0);
    acc(0, 0, 32'h300, 0);
    chk(bt, 32'h4);
  endtask
  task automatic t_inval;
    u_dmem.mem[64] = 32'h77770000;
    acc(0, 0, 32'h100, 0);
    chk(rd, 32'h5a000040);
    inval(1'b0);
    acc(0, 0, 32'h100, 0);
    chk(rd, 32'h77770000);
  endtask
  // Invalidate pulse while a refill runs
  task automatic t_inval_busy;
    fork
      acc(0, 0, 32'h500, 0);
      begin
        @(posedge dcyc);
        dinv <= 1'b1;
        @(posedge clk);
        dinv <= 1'b0;
      end
    join
    chk(rd, 32'h5a000140);
    @(negedge clk);
    chk({31'h0, lsb}, 32'h1);
    acc(0, 0, 32'h500, 0);
    chk(bt, 32'h4);
  endtask
  task automatic t_fetch;
    acc(1, 0, 32'h400, 0);
    chk(bt, 32'h4);
    acc(0, 1, 32'h400, 32'hdead0000);
    acc(1, 0, 32'h400, 0);
    chk(rd, 32'h5a000100);
    chk(lat, 32'h1);
    inval(1'b1);
    acc(1, 0, 32'h400, 0);
    chk(bt, 32'h4);
  endtask
  task automatic t_inline;
    acc(0, 0, 32'h10000040, 0);
    chk(rd, 32'h5a000010);
    acc(0, 0, 32'h10000040, 0);
    chk(bt, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_init;
    t_miss_hit;
    t_store;
    t_rr;
    t_inval;
    t_inval_busy;
    t_fetch;
    t_inline;
    end_of_test;
  end
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
